/* File: pkg/suc_pkg.sv */
/*
  Shared constants and types of the second serial port configuration core.
  Assumes one 250 MHz bus clock and 32-bit AHB-Lite register access.
*/
package suc_pkg;

  // ==========================================================
  // Register indexes, byte address is four times the index
  localparam int ADDR_W = 10;
  localparam logic [7:0] IDX_BDH = 8'hC2;
  localparam logic [7:0] IDX_BDL = 8'hC3;
  localparam logic [7:0] IDX_C1 = 8'hC4;
  localparam logic [7:0] IDX_C2 = 8'hC5;
  localparam logic [7:0] IDX_C3 = 8'hC6;
  localparam logic [7:0] IDX_DATA = 8'hD0;
  localparam logic [7:0] IDX_STAT = 8'hD1;

  // ==========================================================
  // Writable bit masks and reset values
  localparam logic [7:0] BDH_MASK = 8'hDF;
  localparam logic [7:0] C1_MASK = 8'hFD;
  localparam logic [7:0] C3_MASK = 8'h7F;
  localparam logic [7:0] STAT_W1C = 8'h1F;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_STAT = 8'hC0;
  localparam logic [7:0] RST_DATA = 8'hFF;
  localparam logic HRESP_OKAY = 1'b0;

  // ==========================================================
  // Field positions
  localparam int BDH_BRK_IE = 7;
  localparam int BDH_EDGE_IE = 6;
  localparam int DIV_HI_W = 5;
  localparam int DIV_W = 13;
  localparam int C1_LOOP = 7;
  localparam int C1_STOP2 = 6;
  localparam int C1_SINGLE = 5;
  localparam int C1_NINE = 4;
  localparam int C1_PAR_EN = 3;
  localparam int C1_PAR_ODD = 2;
  localparam int C1_EN = 0;
  localparam int C2_TXE_IE = 7;
  localparam int C2_TXC_IE = 6;
  localparam int C2_RXF_IE = 5;
  localparam int C2_LINE_QUIET_IRQ_ON = 4;
  localparam int C2_TX_EN = 3;
  localparam int C2_RX_EN = 2;
  localparam int C2_RWU = 1;
  localparam int C2_BRK = 0;
  localparam int C3_RX9 = 7;
  localparam int C3_TX9 = 6;
  localparam int C3_TXDIR = 5;
  localparam int C3_TXINV = 4;
  localparam int C3_RXINV = 3;
  localparam int C3_WAKE = 0;
  localparam int ST_TXE = 7;
  localparam int ST_TXC = 6;
  localparam int ST_RXF = 5;
  localparam int ST_IDLE = 4;
  localparam int ST_BRK = 3;
  localparam int ST_EDGE = 2;
  localparam int ST_FERR = 1;
  localparam int ST_PERR = 0;

  // ==========================================================
  // Timing in baud ticks
  localparam int OVS = 16;
  localparam logic [3:0] TC_LAST = 4'(OVS - 1);
  localparam logic [3:0] TC_MID = 4'(OVS / 2 - 1);
  localparam logic [3:0] BITS8 = 4'h8;
  localparam logic [3:0] BITS9 = 4'h9;
  localparam logic [3:0] OVH1 = 4'h2;
  localparam logic [3:0] OVH2 = 4'h3;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    FS_IDLE = 2'b00,
    FS_START = 2'b01,
    FS_DATA = 2'b10,
    FS_STOP = 2'b11
  } suc_fsm_t;

  typedef struct packed {
    logic tx_buffer_free;
    logic tx_done;
    logic rx_ready;
    logic line_quiet;
    logic break_detect;
    logic rx_pin_edge;
  } suc_irq_t;

endpackage

/* File: logic/suc_baud_gen.sv */
/*
  Baud tick divider: one enable pulse per divisor count of the bus clock.
  Assumes the divisor is held steady by the register block.
*/
`timescale 1ns/1ps
module suc_baud_gen
  import suc_pkg::*;
#(
  parameter int W = DIV_W
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Control
  input wire logic en_i,
  input wire logic [W-1:0] div_i,
  // Tick
  output logic tick_o
);

  localparam logic [W-1:0] ONE = W'(1);
  localparam logic [W-1:0] ZERO = W'(0);

  logic [W-1:0] cnt;
  logic [W-1:0] next_cnt;
  logic next_tick;

  // ==========================================================
  // Divider
  always_comb
  begin
    next_cnt = cnt + ONE;
    next_tick = 1'b0;
    if (!en_i || div_i == ZERO)
    begin
      next_cnt = ZERO;
    end
    else if (cnt >= div_i - ONE)
    begin
      next_cnt = ZERO;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      cnt <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      tick_o <= next_tick;
    end
  end

endmodule

/* File: logic/suc_core.sv */
/*
  Configuration and control core of the second asynchronous serial port,
  with its frame transmitter and receiver behind an AHB-Lite slave.
  Assumes a single master, word transfers and a synchronous serial line.
*/
// Behaviour
// - Divisor is high register bits 4..0 above all low register bits.
// - A zero divisor produces no baud tick at all.
// - Bit rate is bus clock over sixteen times the divisor.
// - High register bit 7 gates the break detect request.
// - High register bit 6 gates the receive pin edge request.
// - Loop bit ties transmitter to receiver; otherwise separate pins.
// - In loop mode single-wire bit uses transmit pin as shared line.
// - Stop select gives two stop bits at 1, one at 0.
// - Word-length bit selects nine-bit frames, ninth may carry parity.
// - Parity enable turns parity on; type bit picks odd or even.
// - Module enable runs the port; clearing it resets serial logic.
// - Control 2 bits 7 and 6 gate transmit interrupt requests.
// - Control 2 bits 5 and 4 gate receive interrupt requests.
// - Control 2 bit 3 enables transmitter, bit 2 receiver.
// - Wake control holds receiver in standby until wake condition.
// - Writing break bit one then zero sends one break character.
// - Single-wire direction bit drives shared pin out or listens.
// - Polarity bits invert outgoing and incoming serial data.
// - Wake method selects address mark or idle line wake.
// - Control 3 shows received ninth bit and holds transmit ninth.
`timescale 1ns/1ps
module suc_core
  import suc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Serial pins
  input wire logic rxd_i,
  input wire logic txd_i,
  output logic txd_o,
  output logic txd_oe_o,
  // Gated interrupt requests
  output suc_irq_t irq_o
);

  logic [7:0] bdh, bdl, c1, c2, c3, st, tx_buf, rx_buf;
  logic [7:0] next_bdh, next_bdl, next_c1, next_c2, next_c3, next_st;
  logic [7:0] next_tx_buf, next_rx_buf, wr_idx, next_wr_idx, rd;
  logic rx9, next_rx9, brk_pend, next_brk_pend, wr_pend, next_wr_pend;
  logic [31:0] next_hrdata;
  suc_irq_t next_irq;
  logic [7:0] idx;
  logic addr_ok, rd_req, fn_on, tick;
  logic [DIV_W-1:0] divisor;
  logic [3:0] n_bits, stop_last, flen;
  logic [7:0] idle_last;

  suc_fsm_t tx_st, next_tx_st;
  logic [3:0] tx_tc, next_tx_tc, tx_bc, next_tx_bc;
  logic [8:0] tx_sh, next_tx_sh, tx_frame;
  logic tx_brk, next_tx_brk, tx_line, next_tx_line;
  logic next_txd, next_txd_oe;
  logic tx_load, next_tx_load, tx_fin, next_tx_fin;
  logic brk_take, next_brk_take;

  suc_fsm_t rx_st, next_rx_st;
  logic [3:0] rx_tc, next_rx_tc, rx_bc, next_rx_bc;
  logic [8:0] rx_sh, next_rx_sh, rx_fd;
  logic [7:0] rx_icnt, next_rx_icnt, rx_data, next_rx_data;
  logic rx_line, rx_prev, rx_arm, next_rx_arm, rx_addr;
  logic rx_done, rx_perr, rx_ferr, rx_brk, rx_idle, rx_edge, rx_wake;
  logic next_rx_done, next_rx_perr, next_rx_ferr, next_rx_brk;
  logic next_rx_idle, next_rx_edge, next_rx_wake, rx_d9, next_rx_d9;

  // ==========================================================
  // Shared decode and frame shape
  assign divisor = {bdh[DIV_HI_W-1:0], bdl};
  assign fn_on = c1[C1_EN];
  assign idx = haddr_i[ADDR_W-1:2];
  assign addr_ok = (haddr_i[1:0] == 2'b00);
  assign rd_req = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
  assign n_bits = c1[C1_NINE] ? BITS9 : BITS8;
  assign stop_last = c1[C1_STOP2] ? 4'h1 : 4'h0;
  assign flen = n_bits + (c1[C1_STOP2] ? OVH2 : OVH1);
  assign idle_last = {flen, 4'h0} - 8'h01;

  suc_baud_gen #(
    .W(DIV_W)
  ) u_baud (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .en_i(fn_on),
    .div_i(divisor),
    .tick_o(tick)
  );

  // ==========================================================
  // Register file and bus slave
  always_comb
  begin
    next_bdh = bdh;
    next_bdl = bdl;
    next_c1 = c1;
    next_c2 = c2;
    next_c3 = c3;
    next_st = st;
    next_tx_buf = tx_buf;
    next_rx_buf = rx_buf;
    next_rx9 = rx9;
    next_brk_pend = brk_pend;
    next_wr_pend = hsel_i && htrans_i[1] && hready_i && hwrite_i;
    next_wr_idx = addr_ok ? idx : 8'h00;
    rd = RST_REG;
    if (rx_wake)
    begin
      next_c2[C2_RWU] = 1'b0;
    end
    if (tx_load)
    begin
      next_st[ST_TXE] = 1'b1;
      next_st[ST_TXC] = 1'b0;
    end
    if (brk_take)
    begin
      next_brk_pend = 1'b0;
    end
    if (wr_pend)
    begin
      case (wr_idx)
        IDX_BDH: next_bdh = hwdata_i[7:0] & BDH_MASK;
        IDX_BDL: next_bdl = hwdata_i[7:0];
        IDX_C1: next_c1 = hwdata_i[7:0] & C1_MASK;
        IDX_C2:
        begin
          next_c2 = hwdata_i[7:0];
          if (c2[C2_BRK] && !hwdata_i[C2_BRK])
          begin
            next_brk_pend = 1'b1;
          end
        end
        IDX_C3: next_c3 = hwdata_i[7:0] & C3_MASK;
        IDX_DATA:
        begin
          next_tx_buf = hwdata_i[7:0];
          next_st[ST_TXE] = 1'b0;
        end
        IDX_STAT: next_st = next_st & ~(hwdata_i[7:0] & STAT_W1C);
        default: ;
      endcase
    end
    if (rd_req && addr_ok)
    begin
      case (idx)
        IDX_BDH: rd = next_bdh;
        IDX_BDL: rd = next_bdl;
        IDX_C1: rd = next_c1;
        IDX_C2: rd = next_c2;
        IDX_C3: rd = {rx9, next_c3[6:0]};
        IDX_DATA:
        begin
          rd = rx_buf;
          next_st[ST_RXF] = 1'b0;
        end
        IDX_STAT: rd = next_st;
        default: rd = RST_REG;
      endcase
    end
    if (tx_fin)
    begin
      next_st[ST_TXC] = 1'b1;
    end
    if (rx_done)
    begin
      next_st[ST_RXF] = 1'b1;
      next_rx_buf = rx_data;
      next_rx9 = rx_d9;
    end
    next_st[ST_PERR] = next_st[ST_PERR] | rx_perr;
    next_st[ST_FERR] = next_st[ST_FERR] | rx_ferr;
    next_st[ST_BRK] = next_st[ST_BRK] | rx_brk;
    next_st[ST_IDLE] = next_st[ST_IDLE] | rx_idle;
    next_st[ST_EDGE] = next_st[ST_EDGE] | rx_edge;
    if (!next_c1[C1_EN])
    begin
      next_st = RST_STAT;
      next_brk_pend = 1'b0;
    end
    next_hrdata = {24'h00_0000, rd};
    next_irq.tx_buffer_free = next_st[ST_TXE] & next_c2[C2_TXE_IE];
    next_irq.tx_done = next_st[ST_TXC] & next_c2[C2_TXC_IE];
    next_irq.rx_ready = next_st[ST_RXF] & next_c2[C2_RXF_IE];
    next_irq.line_quiet = next_st[ST_IDLE] & next_c2[C2_LINE_QUIET_IRQ_ON];
    next_irq.break_detect = next_st[ST_BRK] & next_bdh[BDH_BRK_IE];
    next_irq.rx_pin_edge = next_st[ST_EDGE] & next_bdh[BDH_EDGE_IE];
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bdh <= RST_REG;
      bdl <= RST_REG;
      c1 <= RST_REG;
      c2 <= RST_REG;
      c3 <= RST_REG;
      st <= RST_STAT;
      tx_buf <= RST_DATA;
      rx_buf <= RST_DATA;
      rx9 <= 1'b0;
      brk_pend <= 1'b0;
      wr_pend <= 1'b0;
      wr_idx <= RST_REG;
      hrdata_o <= '0;
      hreadyout_o <= 1'b1;
      hresp_o <= HRESP_OKAY;
      irq_o <= '0;
    end
    else
    begin
      bdh <= next_bdh;
      bdl <= next_bdl;
      c1 <= next_c1;
      c2 <= next_c2;
      c3 <= next_c3;
      st <= next_st;
      tx_buf <= next_tx_buf;
      rx_buf <= next_rx_buf;
      rx9 <= next_rx9;
      brk_pend <= next_brk_pend;
      wr_pend <= next_wr_pend;
      wr_idx <= next_wr_idx;
      hrdata_o <= next_hrdata;
      hreadyout_o <= 1'b1;
      hresp_o <= HRESP_OKAY;
      irq_o <= next_irq;
    end
  end

  // ==========================================================
  // Transmitter
  always_comb
  begin
    tx_frame = {c3[C3_TX9], tx_buf};
    if (c1[C1_PAR_EN])
    begin
      if (c1[C1_NINE])
      begin
        tx_frame[8] = ^tx_buf ^ c1[C1_PAR_ODD];
      end
      else
      begin
        tx_frame[7] = ^tx_buf[6:0] ^ c1[C1_PAR_ODD];
      end
    end
    next_tx_st = tx_st;
    next_tx_tc = tx_tc;
    next_tx_bc = tx_bc;
    next_tx_sh = tx_sh;
    next_tx_brk = tx_brk;
    next_tx_load = 1'b0;
    next_tx_fin = 1'b0;
    next_brk_take = 1'b0;
    case (tx_st)
      FS_IDLE:
      begin
        next_tx_tc = 4'h0;
        if (c2[C2_TX_EN] && brk_pend)
        begin
          next_tx_sh = '0;
          next_tx_brk = 1'b1;
          next_brk_take = 1'b1;
          next_tx_st = FS_START;
        end
        else if (c2[C2_TX_EN] && !st[ST_TXE])
        begin
          next_tx_sh = tx_frame;
          next_tx_brk = 1'b0;
          next_tx_load = 1'b1;
          next_tx_st = FS_START;
        end
      end
      FS_START:
      begin
        if (tick)
        begin
          next_tx_tc = tx_tc + 4'h1;
          if (tx_tc == TC_LAST)
          begin
            next_tx_bc = 4'h0;
            next_tx_st = FS_DATA;
          end
        end
      end
      FS_DATA:
      begin
        if (tick)
        begin
          next_tx_tc = tx_tc + 4'h1;
          if (tx_tc == TC_LAST)
          begin
            next_tx_sh = {1'b0, tx_sh[8:1]};
            next_tx_bc = tx_bc + 4'h1;
            if (tx_bc == n_bits - 4'h1)
            begin
              next_tx_bc = 4'h0;
              next_tx_st = FS_STOP;
            end
          end
        end
      end
      FS_STOP:
      begin
        if (tick)
        begin
          next_tx_tc = tx_tc + 4'h1;
          if (tx_tc == TC_LAST)
          begin
            next_tx_bc = tx_bc + 4'h1;
            if (tx_bc == stop_last)
            begin
              next_tx_st = FS_IDLE;
              next_tx_fin = 1'b1;
            end
          end
        end
      end
      default: next_tx_st = FS_IDLE;
    endcase
    if (!fn_on)
    begin
      next_tx_st = FS_IDLE;
      next_tx_brk = 1'b0;
      next_tx_load = 1'b0;
      next_brk_take = 1'b0;
    end
    case (next_tx_st)
      FS_START: next_tx_line = 1'b0;
      FS_DATA: next_tx_line = next_tx_sh[0];
      FS_STOP: next_tx_line = !next_tx_brk;
      default: next_tx_line = 1'b1;
    endcase
    next_txd = next_tx_line ^ c3[C3_TXINV];
    if (!c1[C1_LOOP])
    begin
      next_txd_oe = 1'b1;
    end
    else if (c1[C1_SINGLE])
    begin
      next_txd_oe = c3[C3_TXDIR];
    end
    else
    begin
      next_txd_oe = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      tx_st <= FS_IDLE;
      tx_tc <= 4'h0;
      tx_bc <= 4'h0;
      tx_sh <= '0;
      tx_brk <= 1'b0;
      tx_line <= 1'b1;
      txd_o <= 1'b1;
      txd_oe_o <= 1'b1;
      tx_load <= 1'b0;
      tx_fin <= 1'b0;
      brk_take <= 1'b0;
    end
    else
    begin
      tx_st <= next_tx_st;
      tx_tc <= next_tx_tc;
      tx_bc <= next_tx_bc;
      tx_sh <= next_tx_sh;
      tx_brk <= next_tx_brk;
      tx_line <= next_tx_line;
      txd_o <= next_txd;
      txd_oe_o <= next_txd_oe;
      tx_load <= next_tx_load;
      tx_fin <= next_tx_fin;
      brk_take <= next_brk_take;
    end
  end

  // ==========================================================
  // Receiver
  always_comb
  begin
    if (c1[C1_LOOP])
    begin
      rx_line = (c1[C1_SINGLE] ? txd_i : txd_o) ^ c3[C3_RXINV];
    end
    else
    begin
      rx_line = rxd_i ^ c3[C3_RXINV];
    end
    rx_fd = c1[C1_NINE] ? rx_sh : {1'b0, rx_sh[8:1]};
    rx_addr = c1[C1_NINE] ? rx_fd[8] : rx_fd[7];
    next_rx_st = rx_st;
    next_rx_tc = rx_tc;
    next_rx_bc = rx_bc;
    next_rx_sh = rx_sh;
    next_rx_icnt = rx_icnt;
    next_rx_arm = rx_arm;
    next_rx_data = rx_data;
    next_rx_d9 = rx_d9;
    next_rx_done = 1'b0;
    next_rx_perr = 1'b0;
    next_rx_ferr = 1'b0;
    next_rx_brk = 1'b0;
    next_rx_idle = 1'b0;
    next_rx_wake = 1'b0;
    next_rx_edge = rx_prev && !rx_line;
    case (rx_st)
      FS_IDLE:
      begin
        next_rx_tc = 4'h0;
        if (c2[C2_RX_EN] && rx_prev && !rx_line)
        begin
          next_rx_st = FS_START;
          next_rx_icnt = 8'h00;
        end
        else if (!rx_line)
        begin
          next_rx_icnt = 8'h00;
        end
        else if (tick && rx_arm)
        begin
          next_rx_icnt = rx_icnt + 8'h01;
          if (rx_icnt == idle_last)
          begin
            next_rx_idle = 1'b1;
            next_rx_arm = 1'b0;
            next_rx_wake = c2[C2_RWU] && !c3[C3_WAKE];
          end
        end
      end
      FS_START:
      begin
        if (tick)
        begin
          next_rx_tc = rx_tc + 4'h1;
          if (rx_tc == TC_MID)
          begin
            next_rx_tc = 4'h0;
            next_rx_bc = 4'h0;
            next_rx_st = rx_line ? FS_IDLE : FS_DATA;
          end
        end
      end
      FS_DATA:
      begin
        if (tick)
        begin
          next_rx_tc = rx_tc + 4'h1;
          if (rx_tc == TC_LAST)
          begin
            next_rx_sh = {rx_line, rx_sh[8:1]};
            next_rx_bc = rx_bc + 4'h1;
            if (rx_bc == n_bits - 4'h1)
            begin
              next_rx_st = FS_STOP;
            end
          end
        end
      end
      FS_STOP:
      begin
        if (tick)
        begin
          next_rx_tc = rx_tc + 4'h1;
          if (rx_tc == TC_LAST)
          begin
            next_rx_st = FS_IDLE;
            next_rx_arm = 1'b1;
            next_rx_icnt = 8'h00;
            next_rx_data = rx_fd[7:0];
            next_rx_d9 = rx_fd[8];
            next_rx_brk = (rx_fd == 9'h000) && !rx_line;
            if (!c2[C2_RWU] || (c3[C3_WAKE] && rx_addr))
            begin
              next_rx_done = 1'b1;
              next_rx_wake = c2[C2_RWU];
              next_rx_ferr = !rx_line;
              next_rx_perr = c1[C1_PAR_EN] && ((^rx_fd) ^ c1[C1_PAR_ODD]);
            end
          end
        end
      end
      default: next_rx_st = FS_IDLE;
    endcase
    if (!fn_on)
    begin
      next_rx_st = FS_IDLE;
      next_rx_arm = 1'b0;
      next_rx_done = 1'b0;
      next_rx_perr = 1'b0;
      next_rx_ferr = 1'b0;
      next_rx_brk = 1'b0;
      next_rx_idle = 1'b0;
      next_rx_wake = 1'b0;
      next_rx_edge = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rx_st <= FS_IDLE;
      rx_tc <= 4'h0;
      rx_bc <= 4'h0;
      rx_sh <= '0;
      rx_icnt <= 8'h00;
      rx_arm <= 1'b0;
      rx_prev <= 1'b1;
      rx_data <= RST_REG;
      rx_d9 <= 1'b0;
      rx_done <= 1'b0;
      rx_perr <= 1'b0;
      rx_ferr <= 1'b0;
      rx_brk <= 1'b0;
      rx_idle <= 1'b0;
      rx_edge <= 1'b0;
      rx_wake <= 1'b0;
    end
    else
    begin
      rx_st <= next_rx_st;
      rx_tc <= next_rx_tc;
      rx_bc <= next_rx_bc;
      rx_sh <= next_rx_sh;
      rx_icnt <= next_rx_icnt;
      rx_arm <= next_rx_arm;
      rx_prev <= rx_line;
      rx_data <= next_rx_data;
      rx_d9 <= next_rx_d9;
      rx_done <= next_rx_done;
      rx_perr <= next_rx_perr;
      rx_ferr <= next_rx_ferr;
      rx_brk <= next_rx_brk;
      rx_idle <= next_rx_idle;
      rx_edge <= next_rx_edge;
      rx_wake <= next_rx_wake;
    end
  end

endmodule

/* File: testbench/suc_core_asserts.sv */
/*
  Port checker for suc_core, bound to every instance.
  Assumes word writes with the register in the low byte.
*/
`timescale 1ns/1ps
module suc_core_chk
  import suc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // Bus
  input wire logic hsel_i,
  input wire logic [ADDR_W-1:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  // Pins
  input wire logic txd_o,
  input wire logic txd_oe_o,
  input wire suc_irq_t irq_o
);
  // ==========================================================
  // Register shadow
  logic w;
  logic [ADDR_W-1:0] a;
  logic [7:0] bdh, c1, c2, c3;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      w <= 1'b0;
      a <= '0;
      bdh <= 8'h00;
      c1 <= 8'h00;
      c2 <= 8'h00;
      c3 <= 8'h00;
    end
    else
    begin
      w <= hsel_i & htrans_i[1] & hready_i & hwrite_i;
      a <= haddr_i;
      if (w && a == {IDX_BDH, 2'b00}) bdh <= hwdata_i[7:0];
      if (w && a == {IDX_C1, 2'b00}) c1 <= hwdata_i[7:0];
      if (w && a == {IDX_C2, 2'b00}) c2 <= hwdata_i[7:0];
      if (w && a == {IDX_C3, 2'b00}) c3 <= hwdata_i[7:0];
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);
  chk_txe_gate: assert property (
    irq_o.tx_buffer_free |-> c2[7] || $past(c2[7])) else $error("txe ungated");
  chk_txc_gate: assert property (
    irq_o.tx_done |-> c2[6] || $past(c2[6])) else $error("txc ungated");
  chk_rxf_gate: assert property (
    irq_o.rx_ready |-> c2[5] || $past(c2[5])) else $error("rxf ungated");
  chk_idle_gate: assert property (
    irq_o.line_quiet |-> c2[4] || $past(c2[4])) else $error("idle ungated");
  chk_brk_gate: assert property (
    irq_o.break_detect |-> bdh[7] || $past(bdh[7])) else $error("brk ungated");
  chk_edge_gate: assert property (
    irq_o.rx_pin_edge |-> bdh[6] || $past(bdh[6])) else $error("edge ungated");
  chk_pin_drive: assert property (
    $stable({c1, c3}) |-> txd_oe_o == (!c1[7] || (c1[5] && c3[5])))
    else $error("pin direction wrong");
  chk_idle_level: assert property (
    (!c1[0] && $stable(c3[4]))[*3] |-> txd_o == !c3[4])
    else $error("idle level wrong");
endmodule

bind suc_core suc_core_chk u_chk (
  .clk_i(clk_i),
  .resetn_i(resetn_i),
  .hsel_i(hsel_i),
  .haddr_i(haddr_i),
  .htrans_i(htrans_i),
  .hwrite_i(hwrite_i),
  .hwdata_i(hwdata_i),
  .hready_i(hready_i),
  .txd_o(txd_o),
  .txd_oe_o(txd_oe_o),
  .irq_o(irq_o)
);

/* File: testbench/suc_remote.sv */
/*
  Remote serial node: sends and decodes 8-bit frames.
  Assumes a fixed bit time counted in bus clocks.
*/
`timescale 1ns/1ps
module suc_remote #(
  parameter int BIT = 32
)
(
  // Clock
  input wire logic clk_i,
  // Line and frame request
  input wire logic line_i,
  input wire logic send_i,
  input wire logic [7:0] byte_i,
  // Line out and last frame
  output logic rxd_o,
  output logic [7:0] got_o,
  output logic stop_o,
  output int nrx_o
);
  logic [9:0] f;
  logic [8:0] d;
  initial
  begin
    rxd_o = 1'b1;
    nrx_o = 0;
  end
  // ==========================================================
  // Sender and mid-bit receiver
  always @(posedge clk_i)
  begin
    if (send_i)
    begin
      f = {1'b1, byte_i, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
        rxd_o <= f[i];
        repeat (BIT) @(posedge clk_i);
      end
    end
  end
  always
  begin
    @(negedge line_i);
    repeat (BIT / 2) @(posedge clk_i);
    for (int i = 0; i < 9; i++)
    begin
      repeat (BIT) @(posedge clk_i);
      d[i] = line_i;
    end
    got_o = d[7:0];
    stop_o = d[8];
    nrx_o++;
  end
endmodule

/* File: testbench/testbench.sv */
/*
  Bench for suc_core: registers, transmit, receive, loop.
  Assumes the remote node runs at a divisor of two.
*/
`timescale 1ns/1ps
module testbench;
  import suc_pkg::*;
  localparam int LIM = 2000;
  logic clk_i, resetn_i, hsel, hwrite, send, hready, hresp;
  logic txd, txd_oe, rxd, line, stop;
  logic [1:0] htrans;
  logic [9:0] haddr;
  logic [31:0] hwdata, hrdata, q;
  logic [7:0] sbyte, got;
  suc_irq_t irq;
  int failures = 0, comparisons = 0, nrx, n;
  logic [9:0] ra[5] = '{10'h314, 10'h308, 10'h30C, 10'h310, 10'h318};
  logic [7:0] rm[5] = '{8'hFF, BDH_MASK, 8'hFF, C1_MASK, C3_MASK};
  logic [7:0] fc[4] = '{8'h01, 8'h09, 8'h0D, 8'h5D};
  logic [7:0] te[4] = '{8'h03, 8'h03, 8'h83, 8'h03};
  assign line = txd_oe ? txd : 1'b1;
  suc_core u_dut (.clk_i(clk_i), .resetn_i(resetn_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .rxd_i(rxd), .txd_i(line), .txd_o(txd), .txd_oe_o(txd_oe),
    .irq_o(irq));
  suc_remote #(.BIT(32)) u_far (.clk_i(clk_i), .line_i(line),
    .send_i(send), .byte_i(sbyte), .rxd_o(rxd), .got_o(got),
    .stop_o(stop), .nrx_o(nrx));
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // ==========================================================
  // Tasks
  task tally_and_finish;
    if (failures == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task wait_for(input bit irqw, input int n0);
    int k;
    for (k = 0; k < LIM && (irqw ? irq.rx_ready !== 1'b1 : nrx == n0); k++)
      @(posedge clk_i);
    if (k >= LIM)
    begin
      failures++;
      tally_and_finish;
    end
  endtask
  task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    wait_ready;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    wait_ready;
    q = hrdata;
  endtask
  task wait_ready;
    int k;
    k = 0;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (hready !== 1'b1 && k < LIM);
    if (hready !== 1'b1)
    begin
      failures++;
      tally_and_finish;
    end
  endtask
  task rd(input logic [9:0] a, input logic [7:0] e, input string nm);
    bus(1'b0, a, 8'h00);
    chk(nm, {24'h00_0000, e}, q);
  endtask
  // ==========================================================
  // Sequence
  initial
  begin
    resetn_i = 1'b0;
    {hsel, hwrite, send, htrans, haddr, hwdata, sbyte} = '0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      rd(ra[i], 8'h00, "reset");
      bus(1'b1, ra[i], 8'hFF);
      rd(ra[i], rm[i], "mask");
      bus(1'b1, ra[i], 8'h00);
    end
    bus(1'b1, 10'h31C, 8'hFF);
    rd(10'h31C, 8'h00, "unmapped");
    bus(1'b1, 10'h30C, 8'h02);
    bus(1'b1, 10'h314, 8'h08);
    repeat (320) @(posedge clk_i);
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 10'h310, fc[i]);
      n = nrx;
      bus(1'b1, 10'h340, 8'h03);
      wait_for(1'b0, n);
      chk("tx data", te[i], got);
      chk("tx stop", 1, stop);
    end
    chk("txe irq off", 0, irq.tx_buffer_free);
    bus(1'b1, 10'h314, 8'h88);
    repeat (2) @(posedge clk_i);
    chk("txe irq on", 1, irq.tx_buffer_free);
    n = nrx;
    bus(1'b1, 10'h314, 8'h09);
    bus(1'b1, 10'h314, 8'h08);
    wait_for(1'b0, n);
    chk("brk data", 0, got);
    chk("brk stop", 0, stop);
    bus(1'b1, 10'h314, 8'h24);
    bus(1'b1, 10'h30C, 8'h00);
    sbyte <= 8'h5A;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    repeat (400) @(posedge clk_i);
    chk("frozen rx", 0, irq.rx_ready);
    bus(1'b1, 10'h310, 8'h00);
    bus(1'b1, 10'h30C, 8'h02);
    bus(1'b1, 10'h310, 8'h01);
    sbyte <= 8'hA6;
    send <= 1'b1;
    @(posedge clk_i);
    send <= 1'b0;
    wait_for(1'b1, 0);
    chk("rx irq", 1, irq.rx_ready);
    rd(10'h340, 8'hA6, "rx data");
    repeat (2) @(posedge clk_i);
    chk("rx irq clr", 0, irq.rx_ready);
    chk("edge irq off", 0, irq.rx_pin_edge);
    bus(1'b1, 10'h308, 8'h40);
    repeat (2) @(posedge clk_i);
    chk("edge irq on", 1, irq.rx_pin_edge);
    bus(1'b1, 10'h310, 8'h81);
    bus(1'b1, 10'h314, 8'h2C);
    bus(1'b1, 10'h340, 8'h3C);
    wait_for(1'b1, 0);
    rd(10'h340, 8'h3C, "loop data");
    chk("loop oe", 0, txd_oe);
    tally_and_finish;
  end
endmodule
